// ### adsc_pkg.sv
// package: register map, field layout, timing counts and carrier types
package adsc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_UPAT_HI = 2'h1;
  localparam logic [1:0] REG_UPAT_LO = 2'h2;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [7:0] UPAT_RESET = 8'h00;
  localparam logic [7:0] UPAT_HI_MASK = 8'h3F;
  localparam logic [7:0] UPAT_LO_MASK = 8'hFC;
  localparam int UPAT_HI_MSB = 5;
  localparam int UPAT_LO_LSB = 2;
  // ****************************************
  // modes and patterns
  // ****************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_FIXED = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h2;
  localparam logic [11:0] FIXED_PATTERN = 12'hA63;
  localparam logic [1:0] FMT_OB_DCS = 2'h1;
  localparam logic [1:0] FMT_2C_DCS = 2'h2;
  localparam int FMT_TWOS_BIT = 1;
  // ****************************************
  // serial frame, lane and lock timing
  // ****************************************
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] FRAME_FULL = 5'h10;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam logic [3:0] WORD_LAST = 4'hB;
  localparam logic [3:0] HALF_LAST = 4'h5;
  localparam logic [3:0] HALF_SKEW = 4'h3;
  localparam int CLK_MHZ = 50;
  localparam int DLL_LOCK_US = 5;
  localparam int DLL_LOCK_CYC = DLL_LOCK_US * CLK_MHZ;
  localparam int LOCK_W = 9;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(DLL_LOCK_CYC - 1);
  // ****************************************
  // synchronised pin vector positions
  // ****************************************
  localparam int PIN_TOG = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_RELOCK = 2;
  localparam int PIN_TEST = 3;
  localparam int PIN_ALIGN = 4;
  localparam int PIN_LANE = 5;
  localparam int PIN_SLEEP_B = 6;
  localparam int PIN_SLEEP_A = 7;
  localparam int PIN_FMT_LO = 8;
  localparam int PIN_FMT_HI = 9;
  localparam int PIN_SE = 10;
  localparam int PIN_W = 11;
  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [1:0] op_mode_field;
    logic lane_config;
    logic duty_stabilizer_bit;
    logic code_format_bit;
    logic word_align_select;
    logic chan_a_sleep;
    logic chan_b_sleep;
  } adsc_ctrl_type;
  typedef struct packed {
    logic direction_bit;
    logic [4:0] rsvd;
    logic [1:0] addr;
    logic [7:0] data;
  } adsc_frame_type;
  typedef struct packed {
    logic lane_one_out;
    logic lane_zero_out;
    logic lane_zero_oe;
  } adsc_lane_type;
endpackage

// ### adsc_top.sv
// converter control: serial register port, pin/register mode select, lanes
//
// Behaviour
// - sleep pin holds its channel powered down
// - lock output high only while loop locked
// - lane pin one: single lane, zero: dual
// - test pin substitutes fixed pattern, msb first
// - align pin offsets or aligns dual lane words
// - serial enable picks registers over control pins
// - access is sixteen serial clocks after select
// - sample on rising, change output on falling
// - early select release: no address, no write
// - select rising edge latches address, writes data
// - first bit one reads, zero writes
// - three registers; reserved frame bits sent zero
// - output driven only under select, from first falling clock
// - latched address resets to zero
// - mode field picks normal, fixed or user
// - lane bit one: lane zero high impedance
// - bit four stabilizer, bit three code format
// - alignment bit delays lane one one cycle
// - bits one and zero power channels down
// - upper pattern register holds pattern top six
// - lower pattern register holds pattern bottom six
`timescale 1ns/1ns

// ****************************************
// serial clock side of the register port
// ****************************************
module adsc_serial_port
  import adsc_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic serial_select_n,
  input wire logic sdi,
  input wire logic [7:0] ctrl,
  input wire logic [7:0] upat_hi,
  input wire logic [7:0] upat_lo,
  output adsc_frame_type frame,
  output logic done_tog,
  output logic sdo,
  output logic sdo_oe
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] shift;
  } adsc_rx_type;
  typedef struct packed {
    adsc_frame_type hold;
    logic tog;
  } adsc_done_type;
  typedef struct packed {
    logic [7:0] sh;
    logic oe;
  } adsc_tx_type;

  adsc_rx_type rx_q;
  adsc_rx_type rx_d;
  adsc_done_type dn_q;
  adsc_done_type dn_d;
  adsc_tx_type tx_q;
  adsc_tx_type tx_d;
  logic frame_rst_n;

  // a released select clears the frame; the clock may be parked low
  assign frame_rst_n = rst_n & ~serial_select_n;

  function automatic logic [7:0] read_reg(input logic [1:0] a);
    case (a)
      REG_CTRL: read_reg = ctrl;
      REG_UPAT_HI: read_reg = upat_hi;
      REG_UPAT_LO: read_reg = upat_lo;
      default: read_reg = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    rx_d = rx_q;
    if (rx_q.cnt != FRAME_FULL)
    begin
      rx_d.cnt = rx_q.cnt + 5'h01;
      rx_d.shift = {rx_q.shift[14:0], sdi};
    end
  end

  always_comb
  begin
    dn_d = dn_q;
    if (rx_q.cnt == FRAME_LAST)
    begin
      dn_d.hold = {rx_q.shift[14:0], sdi};
      dn_d.tog = ~dn_q.tog;
    end
  end

  always_comb
  begin
    tx_d = tx_q;
    tx_d.oe = 1'b1;
    if (rx_q.cnt == DATA_FIRST)
      tx_d.sh = read_reg(rx_q.shift[1:0]);
    else
      tx_d.sh = {tx_q.sh[6:0], 1'b0};
  end

  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      rx_q <= '0;
    else
      rx_q <= rx_d;
  end

  // completed frame outlives the select so the core can commit it
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
      dn_q <= '0;
    else
      dn_q <= dn_d;
  end

  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      tx_q <= '0;
    else
      tx_q <= tx_d;
  end

  assign frame = dn_q.hold;
  assign done_tog = dn_q.tog;
  assign sdo = tx_q.sh[7];
  assign sdo_oe = tx_q.oe;
endmodule

// ****************************************
// per-channel lane serializer
// ****************************************
module adsc_lane_ser
  import adsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] word,
  input wire logic single,
  input wire logic align,
  input wire logic sleep,
  output adsc_lane_type lanes
);
  typedef struct packed {
    logic [3:0] cnt;
    logic [11:0] sh1;
    logic [5:0] sh0;
    logic [5:0] hold0;
    logic dly;
    adsc_lane_type out;
  } adsc_ser_type;

  adsc_ser_type q;
  adsc_ser_type d;

  always_comb
  begin
    d = q;
    d.sh1 = {q.sh1[10:0], 1'b0};
    d.sh0 = {q.sh0[4:0], 1'b0};
    d.cnt = q.cnt + 4'h1;
    if (single)
    begin
      if (q.cnt >= WORD_LAST)
        d.cnt = 4'h0;
      if (q.cnt == 4'h0)
        d.sh1 = word;
    end
    else
    begin
      if (q.cnt >= HALF_LAST)
        d.cnt = 4'h0;
      if (q.cnt == 4'h0)
      begin
        d.sh1 = {word[11:6], 6'h00};
        d.hold0 = word[5:0];
      end
      // half-word skew starts lane zero three cycles after lane one
      if (q.cnt == (align ? 4'h0 : HALF_SKEW))
        d.sh0 = align ? word[5:0] : q.hold0;
    end
    d.dly = q.sh1[11];
    d.out.lane_one_out = (align && !single) ? q.dly : q.sh1[11];
    d.out.lane_zero_out = single ? 1'b0 : q.sh0[5];
    d.out.lane_zero_oe = ~single;
    if (sleep)
    begin
      d.out.lane_one_out = 1'b0;
      d.out.lane_zero_out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign lanes = q.out;

  property p_sleep_quiet;
    @(posedge clk) disable iff (!rst_n)
    sleep |=> !lanes.lane_one_out && !lanes.lane_zero_out;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("sleeping channel drives lane data");

  property p_single_hiz;
    @(posedge clk) disable iff (!rst_n)
    single ##1 single |-> !lanes.lane_zero_oe;
  endproperty
  a_single_hiz: assert property (p_single_hiz)
    else $error("lane zero driven in single lane mode");
endmodule

// ****************************************
// top: pin sync, registers, mode select, lock
// ****************************************
module adsc_top
  import adsc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] sample_a,
  input wire logic [11:0] sample_b,
  input wire logic over_a_in,
  input wire logic over_b_in,
  input wire logic serial_enable,
  input wire logic [1:0] format_stabilizer_pin,
  input wire logic chan_a_sleep,
  input wire logic chan_b_sleep,
  input wire logic lane_config,
  input wire logic word_align_select,
  input wire logic test_enable,
  input wire logic dll_reset,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output adsc_lane_type lanes_a,
  output adsc_lane_type lanes_b,
  output logic overrange_a,
  output logic overrange_b,
  output logic dll_lock,
  output logic stabilizer_on,
  output logic chan_a_off,
  output logic chan_b_off
);
  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [1:0] cs_dly;
    logic pend;
    logic tog_seen;
    logic [7:0] ctrl;
    logic [7:0] upat_hi;
    logic [7:0] upat_lo;
    logic [1:0] addr;
    logic [LOCK_W-1:0] lock_cnt;
    logic lock;
    adsc_ctrl_type eff;
    logic [11:0] word_a;
    logic [11:0] word_b;
    logic ovr_a;
    logic ovr_b;
  } adsc_top_state_type;

  // select idles high; resetting its sync chain low would fake a release edge
  localparam logic [PIN_W-1:0] SYNC_IDLE = PIN_W'(1) << PIN_CS;
  localparam adsc_top_state_type STATE_RST = '{
    sync1: SYNC_IDLE, sync2: SYNC_IDLE, cs_dly: 2'h3,
    ctrl: CTRL_RESET, upat_hi: UPAT_RESET, upat_lo: UPAT_RESET, default: '0};

  logic [1:0] rst_pipe_q;
  logic rst_n;
  adsc_top_state_type q;
  adsc_top_state_type d;
  adsc_frame_type frame;
  logic done_tog;
  logic [PIN_W-1:0] pins;
  logic se_s;
  logic cs_s;
  logic cs_fall;
  logic tog_new;
  logic commit;
  logic [11:0] user_pat;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_q <= 2'h0;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end
  assign rst_n = rst_pipe_q[1];

  adsc_serial_port u_port (
    .sclk(sclk),
    .rst_n(rst_n),
    .serial_select_n(serial_select_n),
    .sdi(sdi),
    .ctrl(q.ctrl),
    .upat_hi(q.upat_hi),
    .upat_lo(q.upat_lo),
    .frame(frame),
    .done_tog(done_tog),
    .sdo(sdo),
    .sdo_oe(sdo_oe)
  );

  assign pins = {serial_enable, format_stabilizer_pin, chan_a_sleep, chan_b_sleep,
                 lane_config, word_align_select, test_enable, dll_reset,
                 serial_select_n, done_tog};
  assign se_s = q.sync2[PIN_SE];
  assign cs_s = q.sync2[PIN_CS];
  // select is delayed one more stage so the frame toggle is seen first
  assign cs_fall = !q.cs_dly[0] && q.cs_dly[1];
  assign tog_new = q.sync2[PIN_TOG] != q.tog_seen;
  assign commit = (q.cs_dly[0] && !q.cs_dly[1]) && q.pend;
  assign user_pat = {q.upat_hi[UPAT_HI_MSB:0], q.upat_lo[7:UPAT_LO_LSB]};

  function automatic logic [11:0] pick(input logic [11:0] s, input adsc_ctrl_type e,
                                       input logic [11:0] u);
    logic [11:0] n;
    n = e.code_format_bit ? {~s[11], s[10:0]} : s;
    case (e.op_mode_field)
      MODE_FIXED: pick = FIXED_PATTERN;
      MODE_USER: pick = u;
      default: pick = n;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.cs_dly = {q.cs_dly[0], cs_s};
    if (cs_fall)
      d.pend = 1'b0;
    if (tog_new) // set wins over the clear on select fall
    begin
      d.tog_seen = q.sync2[PIN_TOG];
      d.pend = 1'b1;
    end
    if (commit)
    begin
      d.addr = frame.addr;
      if (!frame.direction_bit)
      begin
        case (frame.addr)
          REG_CTRL: d.ctrl = frame.data;
          REG_UPAT_HI: d.upat_hi = frame.data & UPAT_HI_MASK;
          REG_UPAT_LO: d.upat_lo = frame.data & UPAT_LO_MASK;
          default: d.ctrl = q.ctrl;
        endcase
      end
    end
    if (se_s)
      d.eff = adsc_ctrl_type'(q.ctrl);
    else
    begin
      d.eff.op_mode_field = q.sync2[PIN_TEST] ? MODE_FIXED : MODE_NORMAL;
      d.eff.lane_config = q.sync2[PIN_LANE];
      d.eff.duty_stabilizer_bit = (q.sync2[PIN_FMT_HI:PIN_FMT_LO] == FMT_OB_DCS) ||
                                  (q.sync2[PIN_FMT_HI:PIN_FMT_LO] == FMT_2C_DCS);
      d.eff.code_format_bit = q.sync2[PIN_FMT_LO + FMT_TWOS_BIT];
      d.eff.word_align_select = q.sync2[PIN_ALIGN];
      d.eff.chan_a_sleep = q.sync2[PIN_SLEEP_A];
      d.eff.chan_b_sleep = q.sync2[PIN_SLEEP_B];
    end
    // a sleeping channel's pipeline is not valid; it reads as zero
    d.word_a = q.eff.chan_a_sleep ? 12'h000 : pick(sample_a, q.eff, user_pat);
    d.word_b = q.eff.chan_b_sleep ? 12'h000 : pick(sample_b, q.eff, user_pat);
    d.ovr_a = over_a_in && !q.eff.chan_a_sleep;
    d.ovr_b = over_b_in && !q.eff.chan_b_sleep;
    if (q.sync2[PIN_RELOCK])
    begin
      d.lock = 1'b0;
      d.lock_cnt = '0;
    end
    else if (!q.lock)
    begin
      d.lock_cnt = q.lock_cnt + 1'b1;
      if (q.lock_cnt == LOCK_LAST)
        d.lock = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= STATE_RST;
    else
      q <= d;
  end

  adsc_lane_ser u_ser_a (
    .clk(clk),
    .rst_n(rst_n),
    .word(q.word_a),
    .single(q.eff.lane_config),
    .align(q.eff.word_align_select),
    .sleep(q.eff.chan_a_sleep),
    .lanes(lanes_a)
  );

  adsc_lane_ser u_ser_b (
    .clk(clk),
    .rst_n(rst_n),
    .word(q.word_b),
    .single(q.eff.lane_config),
    .align(q.eff.word_align_select),
    .sleep(q.eff.chan_b_sleep),
    .lanes(lanes_b)
  );

  assign overrange_a = q.ovr_a;
  assign overrange_b = q.ovr_b;
  assign dll_lock = q.lock;
  assign stabilizer_on = q.eff.duty_stabilizer_bit;
  assign chan_a_off = q.eff.chan_a_sleep;
  assign chan_b_off = q.eff.chan_b_sleep;

  // ****************************************
  // checks
  // ****************************************
  sequence s_write_commit;
    commit && !frame.direction_bit && frame.addr == REG_CTRL;
  endsequence

  property p_commit_write;
    @(posedge clk) disable iff (!rst_n)
    s_write_commit |=> q.ctrl == $past(frame.data) && q.addr == REG_CTRL;
  endproperty
  a_commit_write: assert property (p_commit_write)
    else $error("control write not stored at select release");

  property p_no_early;
    @(posedge clk) disable iff (!rst_n)
    !q.pend && !tog_new |=> q.addr == $past(q.addr) && q.ctrl == $past(q.ctrl);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("register changed without a complete frame");

  property p_read_keeps;
    @(posedge clk) disable iff (!rst_n)
    commit && frame.direction_bit |=> q.ctrl == $past(q.ctrl);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read access altered a register");

  property p_sdo_hiz;
    @(posedge clk) disable iff (!rst_n)
    serial_select_n |-> !sdo_oe;
  endproperty
  a_sdo_hiz: assert property (p_sdo_hiz)
    else $error("serial output driven without select");

  property p_regs_govern;
    @(posedge clk) disable iff (!rst_n)
    se_s |=> q.eff == adsc_ctrl_type'($past(q.ctrl));
  endproperty
  a_regs_govern: assert property (p_regs_govern)
    else $error("settings not taken from registers");

  property p_fixed_word;
    @(posedge clk) disable iff (!rst_n)
    q.eff.op_mode_field == MODE_FIXED && !q.eff.chan_a_sleep |=> q.word_a == FIXED_PATTERN;
  endproperty
  a_fixed_word: assert property (p_fixed_word)
    else $error("fixed pattern not substituted");

  property p_reserved_mode;
    @(posedge clk) disable iff (!rst_n)
    q.eff.op_mode_field == 2'h3 && !q.eff.chan_a_sleep && !q.eff.code_format_bit
      |=> q.word_a == $past(sample_a);
  endproperty
  a_reserved_mode: assert property (p_reserved_mode)
    else $error("reserved mode did not pass conversion data");

  property p_twos;
    @(posedge clk) disable iff (!rst_n)
    q.eff.op_mode_field == MODE_NORMAL && q.eff.code_format_bit && !q.eff.chan_b_sleep
      |=> q.word_b[11] != $past(sample_b[11]);
  endproperty
  a_twos: assert property (p_twos)
    else $error("two's complement msb not inverted");

  property p_sleep_bit;
    @(posedge clk) disable iff (!rst_n)
    se_s && q.ctrl[1] |=> chan_a_off;
  endproperty
  a_sleep_bit: assert property (p_sleep_bit)
    else $error("channel a not powered down by its bit");

  sequence s_relock_quiet;
    $fell(q.sync2[PIN_RELOCK]) ##1 (!q.sync2[PIN_RELOCK]) [*8];
  endsequence

  property p_lock_wait;
    @(posedge clk) disable iff (!rst_n)
    s_relock_quiet |-> !dll_lock;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("lock reported too soon after relock");

  property p_lock_drop;
    @(posedge clk) disable iff (!rst_n)
    q.sync2[PIN_RELOCK] |=> !dll_lock;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock held during relock pulse");
endmodule

// ### adsc_host.sv
// serial host model driving the converter's register port
`timescale 1ns/1ns

module adsc_host
(
  output logic sclk,
  output logic serial_select_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic oe_seen;

  initial
  begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    sdi = 1'b0;
    oe_seen = 1'b0;
  end

  // ****************************************
  // one access; nb below 16 aborts it early
  // ****************************************
  task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    serial_select_n = 1'b0;
    #32;
    for (int i = 0; i < nb; i++)
    begin
      sdi = f[15 - i];
      #32 sclk = 1'b1;
      if (i >= 8)
        rd = {rd[6:0], sdo};
      if (i == 8)
        oe_seen = sdo_oe;
      #32 sclk = 1'b0;
    end
    #32 serial_select_n = 1'b1;
    // released line must not keep its last level
    sdi = ~sdi;
    #200;
  endtask
endmodule

// ### adc_serial_control_and_modes_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module adc_serial_control_and_modes_bench
  import adsc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] sample_a = 12'h000;
  logic [11:0] sample_b = 12'h000;
  logic over_a_in = 1'b0;
  logic over_b_in = 1'b0;
  logic serial_enable = 1'b0;
  logic [1:0] format_stabilizer_pin = 2'h0;
  logic chan_a_sleep = 1'b0;
  logic chan_b_sleep = 1'b0;
  logic lane_config = 1'b1;
  logic word_align_select = 1'b0;
  logic test_enable = 1'b0;
  logic dll_reset = 1'b0;
  logic sclk, serial_select_n, sdi, sdo, sdo_oe;
  logic overrange_a, overrange_b, dll_lock, stabilizer_on, chan_a_off, chan_b_off;
  adsc_lane_type lanes_a, lanes_b;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'hC6B65B0C;
  logic [7:0] rd, hi, lo;
  logic [11:0] w;

  always #10 clk = ~clk; // sample clock never stops, serial port needs it

  adsc_top adsc_top_inst (.clk(clk), .rstn(rstn), .sample_a(sample_a), .sample_b(sample_b),
    .over_a_in(over_a_in), .over_b_in(over_b_in), .serial_enable(serial_enable),
    .format_stabilizer_pin(format_stabilizer_pin), .chan_a_sleep(chan_a_sleep),
    .chan_b_sleep(chan_b_sleep), .lane_config(lane_config),
    .word_align_select(word_align_select), .test_enable(test_enable), .dll_reset(dll_reset),
    .sclk(sclk), .serial_select_n(serial_select_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .lanes_a(lanes_a), .lanes_b(lanes_b), .overrange_a(overrange_a),
    .overrange_b(overrange_b), .dll_lock(dll_lock), .stabilizer_on(stabilizer_on),
    .chan_a_off(chan_a_off), .chan_b_off(chan_b_off));

  adsc_host adsc_host_inst (.sclk(sclk), .serial_select_n(serial_select_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // word boundary is not visible at the pins, so try every rotation
  function automatic logic [11:0] rot(input logic [11:0] s, input logic [11:0] e, input int n);
    logic [11:0] r;
    for (int k = 0; k < n; k++)
    begin
      r = 12'h000;
      for (int i = 0; i < n; i++)
        r[i] = s[(i + k) % n];
      if (r === e)
        return r;
    end
    return s;
  endfunction

  task automatic settle();
    repeat (30) @(posedge clk);
    #1;
  endtask

  task automatic grab(input logic [11:0] e, input logic dual);
    logic [11:0] s1, s0, b1;
    settle();
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      #1;
      s1 = {s1[10:0], lanes_a.lane_one_out};
      s0 = {s0[10:0], lanes_a.lane_zero_out};
      b1 = {b1[10:0], lanes_b.lane_one_out};
    end
    if (!dual)
    begin
      `CHK(rot(s1, e, 12), e)
      `CHK(lanes_a.lane_zero_oe, 1'b0)
      `CHK(lanes_b.lane_zero_oe, 1'b0)
      // both channels carry the same word in fixed and user pattern modes; only fixed is checked
      if (e === FIXED_PATTERN)
        `CHK(rot(b1, e, 12), e)
    end
    else
    begin
      `CHK(rot(s1, {6'h00, e[11:6]}, 6), {6'h00, e[11:6]})
      `CHK(rot(s0, {6'h00, e[5:0]}, 6), {6'h00, e[5:0]})
      `CHK(lanes_a.lane_zero_oe, 1'b1)
      `CHK(lanes_b.lane_zero_oe, 1'b1)
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d, input int nb);
    logic [7:0] x;
    @(posedge clk);
    #3;
    adsc_host_inst.xfer({1'b0, 5'h00, a, d}, nb, x);
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    #5;
    seed = lfsr(seed);
    // data field of a read carries noise on purpose
    adsc_host_inst.xfer({1'b1, 5'h00, a, seed[7:0]}, 16, d);
    `CHK(adsc_host_inst.oe_seen, 1'b1)
    `CHK(sdo_oe, 1'b0)
  endtask

  task automatic wait_lock();
    for (int i = 0; i < 400 && dll_lock !== 1'b1; i++)
      @(posedge clk);
    `CHK(dll_lock, 1'b1)
    if (dll_lock !== 1'b1)
      print_verdict();
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (3) @(posedge clk);
    seed = lfsr(seed);
    rstn <= 1'b1;
    sample_a <= seed[11:0];
    sample_b <= seed[23:12];
    wait_lock();
    // pin mode: fixed pattern on single and dual lanes
    test_enable <= 1'b1;
    grab(FIXED_PATTERN, 1'b0);
    lane_config <= 1'b0;
    grab(FIXED_PATTERN, 1'b1);
    test_enable <= 1'b0;
    for (int f = 0; f < 4; f++)
    begin
      @(posedge clk);
      format_stabilizer_pin <= 2'(f);
      w = f[1] ? {~sample_a[11], sample_a[10:0]} : sample_a;
      grab(w, 1'b1);
      `CHK(stabilizer_on, 1'(f == 1 || f == 2))
    end
    chan_a_sleep <= 1'b1;
    over_a_in <= 1'b1;
    over_b_in <= 1'b1;
    grab(12'h000, 1'b1);
    `CHK({chan_a_off, chan_b_off, overrange_a, overrange_b}, 4'h9)
    // register mode: pins lose their effect
    serial_enable <= 1'b1;
    grab({~sample_a[11], sample_a[10:0]}, 1'b1);
    `CHK({chan_a_off, stabilizer_on}, 2'h0)
    reg_rd(REG_CTRL, rd);
    `CHK(rd, CTRL_RESET)
    reg_rd(REG_UPAT_HI, rd);
    `CHK(rd, UPAT_RESET)
    reg_rd(REG_UPAT_LO, rd);
    `CHK(rd, UPAT_RESET)
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      hi = seed[7:0];
      lo = seed[15:8];
      reg_wr(REG_UPAT_HI, hi, 16);
      reg_wr(REG_UPAT_LO, lo, 16);
      reg_rd(REG_UPAT_HI, rd);
      `CHK(rd, hi & UPAT_HI_MASK)
      reg_rd(REG_UPAT_LO, rd);
      `CHK(rd, lo & UPAT_LO_MASK)
    end
    reg_wr(REG_UPAT_HI, ~hi, 10);
    reg_rd(REG_UPAT_HI, rd);
    `CHK(rd, hi & UPAT_HI_MASK)
    reg_wr(2'h3, 8'hFF, 16);
    reg_rd(REG_CTRL, rd);
    `CHK(rd, CTRL_RESET)
    reg_rd(2'h3, rd);
    `CHK(rd, 8'h00)
    // every operating mode, single lane, offset binary
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(REG_CTRL, {2'(m), 6'h20}, 16);
      w = (m == 1) ? FIXED_PATTERN : (m == 2) ? {hi[5:0], lo[7:2]} : sample_a;
      grab(w, 1'b0);
    end
    reg_wr(REG_CTRL, 8'h04, 16);
    grab(sample_a, 1'b1);
    reg_wr(REG_CTRL, 8'h12, 16);
    settle();
    `CHK({stabilizer_on, chan_a_off, chan_b_off, overrange_a, overrange_b}, 5'h19)
    reg_wr(REG_CTRL, 8'h01, 16);
    settle();
    `CHK({stabilizer_on, chan_a_off, chan_b_off, overrange_a, overrange_b}, 5'h06)
    // relock pulse of one microsecond
    @(posedge clk);
    dll_reset <= 1'b1;
    repeat (50) @(posedge clk);
    #1;
    `CHK(dll_lock, 1'b0)
    @(posedge clk);
    dll_reset <= 1'b0;
    wait_lock();
    print_verdict();
  end
endmodule
